// file: core/wss_consts.svh
/*
 file holds: register addresses, field positions, widths and reset values of the status block.
 assumes: included by its bare name wherever a constant is needed.
*/
`ifndef WSS_CONSTS_SVH
`define WSS_CONSTS_SVH

// register addresses, seven bits
`define WSS_ADDR_WAKE_A 7'h46
`define WSS_ADDR_WAKE_B 7'h47
`define WSS_ADDR_LEVEL 7'h48
`define WSS_ADDR_OVERLOAD 7'h54
`define WSS_ADDR_OPEN_LOAD 7'h55

// reset and unmapped read values
`define WSS_FLAGS_RESET 8'h00
`define WSS_UNMAPPED_READ 8'h00

// masks of implemented bits, reserved bits read zero
`define WSS_MASK_WAKE_A 8'hF7
`define WSS_MASK_WAKE_B 8'h30
`define WSS_MASK_LEVEL 8'hF7
`define WSS_MASK_HS 8'h0F

// field positions in the first wake register
`define WSS_BIT_TIMER 4
`define WSS_BIT_RSVD_A 3
// field positions in the second wake register
`define WSS_BIT_GP_ONE_WAKE 4
`define WSS_BIT_GP_TWO_WAKE 5
// field positions in the level register
`define WSS_BIT_DEV_MODE 7
`define WSS_BIT_CFG_PULLUP 6
`define WSS_BIT_GP_TWO_LVL 5
`define WSS_BIT_GP_ONE_LVL 4

// serial frame layout, msb first
`define WSS_FRAME_BITS 5'd16
`define WSS_FRAME_LAST 5'd15
`define WSS_RESP_BITS 5'd8
`define WSS_ADDR_MSB 15
`define WSS_ADDR_LSB 9
`define WSS_RW_BIT 8
`define WSS_CNT_ZERO 5'd0
`define WSS_CNT_ONE 5'd1
`define WSS_RESP_MSB 3'd7

`endif

// file: core/wss_pkg.sv
/*
 file holds: the types shared by the status block.
 assumes: compiled before every module of the block.
*/
package wss_pkg;

  // supply mode of the device
  typedef enum logic [1:0] {
    WSS_MODE_NORMAL,
    WSS_MODE_STOP,
    WSS_MODE_SLEEP,
    WSS_MODE_FAIL_SAFE
  } wss_mode_e;

  // function selected on one general-purpose pin
  typedef enum logic [1:0] {
    WSS_GP_OFF,
    WSS_GP_WAKE,
    WSS_GP_LOW_SIDE,
    WSS_GP_HIGH_SIDE
  } wss_gp_cfg_e;

  // one wake event line per source of the first wake register
  typedef struct packed {
    logic second_lin_wake_flag;
    logic first_lin_wake_flag;
    logic can_bus_wake_flag;
    logic cyclic_timer_wake_flag;
    logic wake_input_three_flag;
    logic wake_input_two_flag;
    logic wake_input_one_flag;
  } wss_wake_s;

  // all asynchronous detector and pin inputs, crossed together
  typedef struct packed {
    wss_wake_s wake;
    logic [1:0] gp_wake;
    logic [3:0] overload;
    logic [3:0] open_load;
    logic [2:0] wake_pin;
    logic [1:0] gp_pin;
    logic dev_strap;
    logic cfg_pullup;
  } wss_async_s;

  // request word from the link domain
  typedef struct packed {
    logic [6:0] addr;
    logic write;
  } wss_req_s;

endpackage : wss_pkg

// file: core/wss_status_regs.sv
/*
 file holds: the wake, level and high-side switch status registers with their serial read port.
 assumes: detectors drive level event inputs; the host leaves at least eight core clocks between frames.
*/
// Summary of operation
// - wake events set per-source flags in first register
// - fail-safe wake exit sets the causing source flag
// - reserved status bits always read zero
// - level bit 7 shows development mode strap
// - level bit 6 shows interrupt pull-up detected
// - level bits show wake inputs and general pins
// - pin levels refresh in normal, stop when configured
// - cyclic sense holds last sampled wake level
// - general pins never sampled cyclically
// - pin level shown even as switch
// - overload flags set per high-side switch
// - open-load flags set per high-side switch
// - power-on and soft reset clear all flags
// - restart keeps first wake register flags
`include "wss_consts.svh"

module wss_status_regs (
  input wire logic core_clk, // 10 MHz core clock
  input wire logic srst, // power-on reset, high; synchronous in the core domain, asynchronous in the link domain
  input wire logic clk_en, // freezes core state when low
  input wire logic soft_rst, // soft reset pulse, core domain
  input wire wss_pkg::wss_mode_e sbc_mode, // current device mode
  input wire wss_pkg::wss_gp_cfg_e gp_one_cfg, // function of first pin
  input wire wss_pkg::wss_gp_cfg_e gp_two_cfg, // function of second pin
  input wire logic [2:0] wake_cyclic_en, // wake inputs in cyclic sense
  input wire logic wake_sample_strobe, // one pulse per sampling instant
  input wire logic failsafe_wake_exit, // pulse, leaving fail-safe by wake
  input wire wss_pkg::wss_wake_s failsafe_wake_src, // source of that wake
  input wire wss_pkg::wss_async_s async_in, // detector events and pins
  input wire logic link_clk, // serial clock from the host
  input wire logic link_csn, // serial select, low in a frame
  input wire logic link_sdi, // serial data in
  output logic link_sdo, // serial data out
  output logic link_sdo_oe // high while driving serial data
);

  wss_pkg::wss_async_s in_sync; // crossed asynchronous inputs
  logic [7:0] wake_a; // first wake status register
  logic [7:0] wake_b; // second wake status register
  logic [7:0] level; // live input level register
  logic [7:0] overload; // overload status register
  logic [7:0] open_load; // open-load status register
  logic [7:0] resp; // read answer, held for the next frame
  logic [7:0] wake_a_set; // set terms of the first register
  logic [7:0] wake_b_set; // set terms of the second register
  logic clr_a; // read-clear of the first register
  logic clr_b; // read-clear of the second register
  logic clr_ovl; // read-clear of overload
  logic clr_opl; // read-clear of open-load
  logic flag_rst; // power-on or soft reset
  logic gp_refresh; // general pin levels may refresh
  logic [2:0] wake_take; // wake levels taken this cycle
  // link domain
  logic [4:0] bit_cnt; // bit position within a frame
  logic [7:0] shift_in; // incoming address and rw bits, first eight of the frame
  logic req_tgl; // toggles once per finished frame
  wss_pkg::wss_req_s req_word; // last finished request
  // core side of the request handshake
  logic req_tgl_sync; // crossed request toggle
  logic req_seen; // last toggle value handled
  logic req_new; // a request waits this cycle
  logic req_read; // that request clears what it reads

  // address hit, used by the mux and the clear strobes
  function automatic logic addr_hit(input logic [6:0] addr, input logic [6:0] target);
    addr_hit = (addr == target);
  endfunction : addr_hit

  // read value of one address, reserved bits masked
  function automatic logic [7:0] read_value(input logic [6:0] addr, input logic [7:0] ra, input logic [7:0] rb,
                                            input logic [7:0] lv, input logic [7:0] ol, input logic [7:0] op);
    read_value = `WSS_UNMAPPED_READ;
    if (addr_hit(addr, `WSS_ADDR_WAKE_A)) begin
      read_value = ra & `WSS_MASK_WAKE_A;
    end else if (addr_hit(addr, `WSS_ADDR_WAKE_B)) begin
      read_value = rb & `WSS_MASK_WAKE_B;
    end else if (addr_hit(addr, `WSS_ADDR_LEVEL)) begin
      read_value = lv & `WSS_MASK_LEVEL;
    end else if (addr_hit(addr, `WSS_ADDR_OVERLOAD)) begin
      read_value = ol & `WSS_MASK_HS;
    end else if (addr_hit(addr, `WSS_ADDR_OPEN_LOAD)) begin
      read_value = op & `WSS_MASK_HS;
    end
  endfunction : read_value

  // cross every detector and pin input
  wss_sync #(
    .WIDTH($bits(wss_pkg::wss_async_s))
  ) u_in_sync (
    .clk(core_clk),
    .clk_en(clk_en),
    .din(async_in),
    .dout(in_sync)
  );

  // cross the request toggle from the link domain
  wss_sync #(
    .WIDTH(1)
  ) u_req_sync (
    .clk(core_clk),
    .clk_en(clk_en),
    .din(req_tgl),
    .dout(req_tgl_sync)
  );

  // link domain: bit counter, cleared while select is high
  always_ff @(posedge link_clk or posedge link_csn) begin
    if (link_csn) begin
      bit_cnt <= `WSS_CNT_ZERO;
    end else if (bit_cnt != `WSS_FRAME_BITS) begin
      bit_cnt <= bit_cnt + `WSS_CNT_ONE;
    end
  end

  // link domain: shift in address and rw bit; the filler byte must not push them out
  always_ff @(posedge link_clk) begin
    if (!link_csn && bit_cnt < `WSS_RESP_BITS) begin
      shift_in <= {shift_in[6:0], link_sdi};
    end
  end

  // link domain: hand a finished frame to the core
  always_ff @(posedge link_clk or posedge srst) begin
    if (srst) begin
      req_tgl <= 1'b0;
      req_word <= '0;
    end else if (!link_csn && bit_cnt == `WSS_FRAME_LAST) begin
      req_word <= wss_pkg::wss_req_s'(shift_in);
      req_tgl <= ~req_tgl;
    end
  end

  // link domain: answer bits out, msb first, during the first eight clocks
  always_ff @(posedge link_clk or posedge link_csn) begin
    if (link_csn) begin
      link_sdo <= 1'b0;
      link_sdo_oe <= 1'b0;
    end else begin
      link_sdo_oe <= 1'b1;
      if (bit_cnt < `WSS_RESP_BITS) begin
        link_sdo <= resp[`WSS_RESP_MSB - bit_cnt[2:0]]; // resp held stable between frames
      end else begin
        link_sdo <= 1'b0;
      end
    end
  end

  // request decode in the core domain
  always_comb begin
    req_new = (req_tgl_sync != req_seen);
    req_read = req_new && !req_word.write;
    clr_a = req_read && addr_hit(req_word.addr, `WSS_ADDR_WAKE_A);
    clr_b = req_read && addr_hit(req_word.addr, `WSS_ADDR_WAKE_B);
    clr_ovl = req_read && addr_hit(req_word.addr, `WSS_ADDR_OVERLOAD);
    clr_opl = req_read && addr_hit(req_word.addr, `WSS_ADDR_OPEN_LOAD);
    flag_rst = srst || soft_rst;
  end

  // take a request and latch the answer
  always_ff @(posedge core_clk) begin
    if (srst) begin
      req_seen <= req_tgl_sync;
      resp <= `WSS_UNMAPPED_READ;
    end else if (clk_en && req_new) begin
      req_seen <= req_tgl_sync;
      resp <= read_value(req_word.addr, wake_a, wake_b, level, overload, open_load);
    end
  end

  // set terms: detector events plus the fail-safe wake source
  always_comb begin
    wake_a_set = {in_sync.wake[6:3], 1'b0, in_sync.wake[2:0]};
    if (failsafe_wake_exit) begin
      wake_a_set = wake_a_set | {failsafe_wake_src[6:3], 1'b0, failsafe_wake_src[2:0]};
    end
    wake_b_set = `WSS_FLAGS_RESET;
    wake_b_set[`WSS_BIT_GP_ONE_WAKE] = in_sync.gp_wake[0];
    wake_b_set[`WSS_BIT_GP_TWO_WAKE] = in_sync.gp_wake[1];
  end

  // wake flags, set wins over read-clear; a restart does not touch them
  always_ff @(posedge core_clk) begin
    if (flag_rst) begin
      wake_a <= `WSS_FLAGS_RESET;
      wake_b <= `WSS_FLAGS_RESET;
    end else if (clk_en) begin
      wake_a <= ((wake_a & ~{8{clr_a}}) | wake_a_set) & `WSS_MASK_WAKE_A;
      wake_b <= ((wake_b & ~{8{clr_b}}) | wake_b_set) & `WSS_MASK_WAKE_B;
    end
  end

  // high-side switch flags, set wins over read-clear
  always_ff @(posedge core_clk) begin
    if (flag_rst) begin
      overload <= `WSS_FLAGS_RESET;
      open_load <= `WSS_FLAGS_RESET;
    end else if (clk_en) begin
      overload <= ((overload & ~{8{clr_ovl}}) | {4'h0, in_sync.overload}) & `WSS_MASK_HS;
      open_load <= ((open_load & ~{8{clr_opl}}) | {4'h0, in_sync.open_load}) & `WSS_MASK_HS;
    end
  end

  // refresh conditions of the level register
  always_comb begin
    gp_refresh = (sbc_mode == wss_pkg::WSS_MODE_NORMAL) || (sbc_mode == wss_pkg::WSS_MODE_STOP);
    wake_take = ~wake_cyclic_en | {3{wake_sample_strobe}};
  end

  // level register: strap and pull-up live, wake inputs per sampling mode
  always_ff @(posedge core_clk) begin
    if (srst) begin
      level <= `WSS_FLAGS_RESET;
    end else if (clk_en) begin
      level[`WSS_BIT_DEV_MODE] <= in_sync.dev_strap;
      level[`WSS_BIT_CFG_PULLUP] <= in_sync.cfg_pullup;
      level[`WSS_BIT_RSVD_A] <= 1'b0;
      // general pins follow the pin, never the sampling strobe
      if (gp_refresh && gp_one_cfg != wss_pkg::WSS_GP_OFF) begin
        level[`WSS_BIT_GP_ONE_LVL] <= in_sync.gp_pin[0];
      end
      if (gp_refresh && gp_two_cfg != wss_pkg::WSS_GP_OFF) begin
        level[`WSS_BIT_GP_TWO_LVL] <= in_sync.gp_pin[1];
      end
      for (int i = 0; i < 3; i++) begin
        if (wake_take[i]) begin
          level[i] <= in_sync.wake_pin[i];
        end
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  chk_rsvd_bits_zero: assert property (wake_a[3] == 1'b0 && wake_b[7:6] == 2'b00 && wake_b[3:0] == 4'h0
                                       && overload[7:4] == 4'h0 && open_load[7:4] == 4'h0)
    else $error("reserved status bit set");
  chk_wake_event_set: assert property (clk_en && !soft_rst && in_sync.wake.can_bus_wake_flag
                                       |=> wake_a[5])
    else $error("bus wake flag not set");
  chk_failsafe_src_set: assert property (clk_en && !soft_rst && failsafe_wake_exit
                                         && failsafe_wake_src.cyclic_timer_wake_flag
                                         |=> wake_a[`WSS_BIT_TIMER])
    else $error("fail-safe wake source not flagged");
  chk_strap_follows: assert property (clk_en |=> level[7] == $past(in_sync.dev_strap))
    else $error("mode strap level wrong");
  chk_gp_frozen_sleep: assert property (clk_en && sbc_mode == wss_pkg::WSS_MODE_SLEEP
                                        |=> $stable(level[5:4]))
    else $error("pin level moved outside normal or stop");
  chk_wake_hold_cyclic: assert property (clk_en && wake_cyclic_en[0] && !wake_sample_strobe
                                         |=> $stable(level[0]))
    else $error("cyclic wake level moved without sampling");
  chk_overload_sticky: assert property (overload[0] && !clr_ovl && !soft_rst |=> overload[0])
    else $error("overload flag lost without read");
  chk_soft_clears: assert property (soft_rst |=> wake_a == 8'h00 && overload == 8'h00
                                    && open_load == 8'h00)
    else $error("soft reset left a flag");
  chk_read_clears: assert property (clr_opl && clk_en && !soft_rst && in_sync.open_load == 4'h0
                                    |=> open_load == 8'h00)
    else $error("read did not clear open-load flags");

endmodule : wss_status_regs

// file: core/wss_sync.sv
/*
 file holds: a two flip-flop synchroniser for a vector of independent levels.
 assumes: each bit is a slow level; no bit-to-bit coherence is needed.
*/
module wss_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta; // first stage, read only by the second

  // two stage crossing
  always_ff @(posedge clk) begin
    if (clk_en) begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule : wss_sync

// file: tb/testbench.sv
/*
 holds: self-checking bench of the status registers, read through serial frames.
 assumes: two-frame reads; inputs change at core_clk rising edges.
*/
`include "wss_consts.svh"
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk, srst, clk_en, soft_rst, strobe, fs_exit; // core controls
  wss_pkg::wss_mode_e mode; // device mode
  wss_pkg::wss_gp_cfg_e cfg1, cfg2; // pin functions
  logic [2:0] cyc; // cyclic sense enables
  wss_pkg::wss_wake_s fs_src; // fail-safe wake source
  wss_pkg::wss_async_s ain; // detectors and pin levels
  logic lclk, lcsn, lsdi, lsdo, loe; // serial link
  int err_total, comparisons, cyc_cnt;
  logic [7:0] v; // value read
  logic [6:0] regs [6] = '{`WSS_ADDR_WAKE_A, `WSS_ADDR_WAKE_B, `WSS_ADDR_LEVEL,
                           `WSS_ADDR_OVERLOAD, `WSS_ADDR_OPEN_LOAD, 7'h00};
  wss_status_regs DUT (.core_clk(core_clk), .srst(srst), .clk_en(clk_en), .soft_rst(soft_rst),
    .sbc_mode(mode), .gp_one_cfg(cfg1), .gp_two_cfg(cfg2), .wake_cyclic_en(cyc),
    .wake_sample_strobe(strobe), .failsafe_wake_exit(fs_exit), .failsafe_wake_src(fs_src),
    .async_in(ain), .link_clk(lclk), .link_csn(lcsn), .link_sdi(lsdi), .link_sdo(lsdo),
    .link_sdo_oe(loe));
  wss_host host (.link_clk(lclk), .link_csn(lcsn), .link_sdi(lsdi), .link_sdo(lsdo),
    .link_sdo_oe(loe));
  // 10 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // hang guard
  always @(posedge core_clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      err_total++;
      tally_and_finish();
    end
  end
  // compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // request frame, then a no-clear frame to an unmapped place fetches the answer
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    logic [7:0] x;
    host.xfer(a, 1'b0, x);
    host.xfer(7'h00, 1'b1, d);
  endtask : rd
  // event lines high for three cycles, then low
  task automatic ev(input logic [16:0] e);
    @(posedge core_clk) ain[23:7] <= e;
    repeat (3) @(posedge core_clk);
    ain[23:7] <= '0;
    repeat (3) @(posedge core_clk);
  endtask : ev
  // set pin levels, let them settle, read the level register
  task automatic lv(input logic [6:0] l, input logic [7:0] exp);
    @(posedge core_clk) ain[6:0] <= l;
    repeat (4) @(posedge core_clk);
    rd(`WSS_ADDR_LEVEL, v);
    chk(v, exp);
  endtask : lv
  // verdict
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish
  // main sequence
  initial begin
    {srst, clk_en, soft_rst, strobe, fs_exit, cyc, fs_src, ain} = '0;
    srst = 1'b1;
    clk_en = 1'b1;
    mode = wss_pkg::WSS_MODE_NORMAL;
    cfg1 = wss_pkg::WSS_GP_HIGH_SIDE;
    cfg2 = wss_pkg::WSS_GP_LOW_SIDE;
    {err_total, comparisons, cyc_cnt} = '0;
    repeat (8) @(posedge core_clk);
    srst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      rd(regs[i], v);
      chk(v, 8'h00);
    end
    chk({7'h00, host.oe_seen}, 8'h01);
    chk({7'h00, loe}, 8'h00);
    $display("reset values done");
    // each wake source alone, reserved bit 3 skipped
    for (int i = 0; i < 7; i++) begin
      ev({7'(1 << i), 10'h000});
      rd(`WSS_ADDR_WAKE_A, v);
      chk(v, (i < 3) ? 8'(1 << i) : 8'(1 << (i + 1)));
    end
    $display("wake sources done");
    // everything at once; a write frame must not clear
    ev({7'h7F, 2'b11, 4'hF, 4'hF});
    host.xfer(`WSS_ADDR_OVERLOAD, 1'b1, v);
    rd(`WSS_ADDR_WAKE_A, v);
    chk(v, 8'hF7);
    rd(`WSS_ADDR_WAKE_B, v);
    chk(v, 8'h30);
    rd(`WSS_ADDR_OVERLOAD, v);
    chk(v, 8'h0F);
    rd(`WSS_ADDR_OPEN_LOAD, v);
    chk(v, 8'h0F);
    rd(`WSS_ADDR_OVERLOAD, v);
    chk(v, 8'h00);
    $display("flag sets done");
    // leaving fail-safe by a bus wake
    @(posedge core_clk) fs_src <= 7'h10;
    fs_exit <= 1'b1;
    @(posedge core_clk) fs_exit <= 1'b0;
    rd(`WSS_ADDR_WAKE_A, v);
    chk(v, 8'h20);
    // bus and timer together
    @(posedge core_clk) fs_src <= 7'h18;
    fs_exit <= 1'b1;
    @(posedge core_clk) fs_exit <= 1'b0;
    rd(`WSS_ADDR_WAKE_A, v);
    chk(v, 8'h30);
    // soft reset wipes pending flags
    ev({7'h41, 2'b01, 4'hA, 4'h5});
    @(posedge core_clk) soft_rst <= 1'b1;
    @(posedge core_clk) soft_rst <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      if (i != 2) begin
        rd(regs[i], v);
        chk(v, 8'h00);
      end
    end
    $display("fail-safe and soft reset done");
    // level register: {wake pins, gp pins, strap, pull-up}
    lv({3'b101, 2'b10, 1'b1, 1'b1}, 8'hE5);
    lv({3'b010, 2'b01, 1'b0, 1'b0}, 8'h12);
    @(posedge core_clk) mode <= wss_pkg::WSS_MODE_SLEEP;
    lv({3'b010, 2'b10, 1'b0, 1'b0}, 8'h12);
    @(posedge core_clk) mode <= wss_pkg::WSS_MODE_STOP;
    cfg1 <= wss_pkg::WSS_GP_OFF;
    cfg2 <= wss_pkg::WSS_GP_OFF;
    lv({3'b010, 2'b10, 1'b0, 1'b0}, 8'h12);
    @(posedge core_clk) cfg1 <= wss_pkg::WSS_GP_WAKE;
    cfg2 <= wss_pkg::WSS_GP_WAKE;
    lv({3'b010, 2'b10, 1'b0, 1'b0}, 8'h22);
    @(posedge core_clk) cyc <= 3'b111;
    lv({3'b101, 2'b01, 1'b0, 1'b0}, 8'h12);
    @(posedge core_clk) strobe <= 1'b1;
    @(posedge core_clk) strobe <= 1'b0;
    rd(`WSS_ADDR_LEVEL, v);
    chk(v, 8'h15);
    $display("level register done");
    tally_and_finish();
  end
endmodule : testbench

// file: tb/wss_host.sv
/*
 holds: host serial master model sending 16-bit frames, msb first.
 assumes: the device answers the previous frame's request on link_sdo.
*/
module wss_host (
  output logic link_clk, // stands low outside frames
  output logic link_csn, // low in a frame
  output logic link_sdi, // address, write flag, filler
  input wire logic link_sdo, // answer bits
  input wire logic link_sdo_oe // drive enable, sampled once per frame
);
  timeunit 1ns;
  timeprecision 100ps;
  logic oe_seen; // drive enable seen after the first clock of the last frame
  // idle levels; a clean deselect edge resets the link side counter
  initial begin
    link_clk = 1'b0;
    link_csn = 1'b0;
    link_sdi = 1'b0;
    oe_seen = 1'b0;
    #1 link_csn = 1'b1;
  end
  // one whole frame; a read with wr low clears the flags it names
  task automatic xfer(input logic [6:0] addr, input logic wr, output logic [7:0] resp);
    logic [15:0] word;
    word = {addr, wr, 8'h5A};
    #3.3 link_csn = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      link_sdi = word[i];
      #7.5 link_clk = 1'b1;
      #7.5 link_clk = 1'b0;
      // answer sampled on the falling edge
      if (i > 7) begin
        resp[i - 8] = link_sdo;
      end
      if (i == 15) begin
        oe_seen = link_sdo_oe;
      end
    end
    #7.5 link_csn = 1'b1;
    link_sdi = ~link_sdi; // no stale value once deselected
    #1000; // gap above eight core clocks
  endtask : xfer
endmodule : wss_host
